//--- logic/dscs_top.sv
// Purpose: crystal clock divide and double speed selection
// Assumes: crystal_input is sampled at core_clk_i, slower than half rate
// Notes: clocks leave as one-cycle enables, not as derived clocks
`timescale 1ns/1ps
`include "dscs_defines.svh"
module dscs_top (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic crystal_input_i,
  input wire dscs_pkg::dscs_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire dscs_pkg::dscs_nv_op_t nv_op_i,
  input wire logic nv_op_valid_i,
  output logic nv_opt_o,
  input wire logic [1:0] serial_mode_i,
  output logic double_speed_mode_o,
  output logic phase_tick_o,
  output logic mach_cycle_o,
  output logic [`DSCS_NUM_PER-1:0] per_tick_o
);
  logic xin_s1_reg, xin_s2_reg, xin_d_reg;
  logic half_reg;
  logic nv_opt_reg;
  logic init_reg;
  logic [7:0] css_reg;
  logic dsm_act_reg;
  logic xin_rise, half_rise, css_hit;
  logic [3:0] mc_cnt_reg;
  logic [`DSCS_NUM_PER-1:0] per_slow;

  assign css_hit = sfr_req_i.sel && sfr_req_i.addr == `DSCS_CSS_ADDR;

  // two-stage synchroniser; only the second stage is observed
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      xin_s1_reg <= 1'b0;
      xin_s2_reg <= 1'b0;
      xin_d_reg <= 1'b0;
    end else begin
      xin_s1_reg <= crystal_input_i;
      xin_s2_reg <= xin_s1_reg;
      xin_d_reg <= xin_s2_reg;
    end
  end
  assign xin_rise = xin_s2_reg && !xin_d_reg;

  // halving on rising edges only makes duty cycle irrelevant
  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      half_reg <= 1'b0;
    else if (xin_rise)
      half_reg <= !half_reg;
  end
  assign half_rise = xin_rise && !half_reg;

  // nonvolatile start option, kept across reset like a fuse
  always_ff @(posedge core_clk_i) begin
    if (nv_op_valid_i && nv_op_i == dscs_pkg::DSCS_OP_SET)
      nv_opt_reg <= 1'b1;
    else if (nv_op_valid_i && nv_op_i == dscs_pkg::DSCS_OP_CLEAR)
      nv_opt_reg <= 1'b0;
  end
  assign nv_opt_o = nv_opt_reg === 1'b1;

  // option is loaded one cycle after reset release
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      css_reg <= `DSCS_CSS_RESET;
      init_reg <= 1'b1;
    end else begin
      init_reg <= 1'b0;
      if (init_reg && nv_opt_o)
        css_reg[`DSCS_BIT_DSM] <= 1'b1;
      else if (css_hit && sfr_req_i.wr)
        css_reg <= sfr_req_i.wdata;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      sfr_rdata_o <= 8'h00;
    else if (css_hit && !sfr_req_i.wr)
      sfr_rdata_o <= css_reg;
  end

  // mode takes effect only at a halved-clock rising edge or at the start option load, avoiding glitches
  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      dsm_act_reg <= 1'b0;
    // option load wins so a coinciding halved edge cannot mask it
    else if (half_rise || (init_reg && nv_opt_o))
      dsm_act_reg <= (init_reg && nv_opt_o) ? 1'b1 :
        css_reg[`DSCS_BIT_DSM];
  end
  assign double_speed_mode_o = dsm_act_reg;

  // bypass takes every crystal edge, else every second one
  assign phase_tick_o = dsm_act_reg ? xin_rise : half_rise;

  // six phase ticks per machine cycle: 6 or 12 crystal periods
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mc_cnt_reg <= 4'h0;
      mach_cycle_o <= 1'b0;
    end else begin
      mach_cycle_o <= 1'b0;
      if (phase_tick_o) begin
        if (mc_cnt_reg >= {1'b0, `DSCS_PER_FAST}) begin
          mc_cnt_reg <= 4'h0;
          mach_cycle_o <= 1'b1;
        end else begin
          mc_cnt_reg <= mc_cnt_reg + 4'h1;
        end
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DSCS_NUM_PER; gi++) begin : g_per
      if (gi + 1 == `DSCS_BIT_SP) begin : g_sp
        assign per_slow[gi] = !dsm_act_reg || css_reg[gi+1] ||
          !(serial_mode_i == 2'h0 || serial_mode_i == 2'h2);
      end else begin : g_oth
        assign per_slow[gi] = !dsm_act_reg || css_reg[gi+1];
      end
      dscs_per_div u_div (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .tick_i(xin_rise),
        .slow_i(per_slow[gi]),
        .pulse_o(per_tick_o[gi])
      );
    end
  endgenerate

  property p_bypass_tick;
    @(posedge core_clk_i) disable iff (srst_i)
      dsm_act_reg && xin_rise |-> phase_tick_o;
  endproperty
  a_bypass_tick: assert property (p_bypass_tick)
    else $error("double speed missed a crystal tick");

  property p_std_halves;
    @(posedge core_clk_i) disable iff (srst_i)
      !dsm_act_reg && xin_rise && half_reg |-> !phase_tick_o;
  endproperty
  a_std_halves: assert property (p_std_halves)
    else $error("standard mode ticked on the odd edge");

  property p_switch_edge;
    @(posedge core_clk_i) disable iff (srst_i)
      !init_reg && $past(!init_reg) && $changed(dsm_act_reg)
        |-> $past(half_rise);
  endproperty
  a_switch_edge: assert property (p_switch_edge)
    else $error("mode changed off a halved clock edge");

  property p_reset_std;
    @(posedge core_clk_i) $fell(srst_i) |-> !dsm_act_reg;
  endproperty
  a_reset_std: assert property (p_reset_std)
    else $error("mode not standard after reset");

  property p_start_opt;
    @(posedge core_clk_i) disable iff (srst_i)
      init_reg && nv_opt_o |=> dsm_act_reg && css_reg[0];
  endproperty
  a_start_opt: assert property (p_start_opt)
    else $error("start option ignored");

  property p_nv_set;
    @(posedge core_clk_i)
      nv_op_valid_i && nv_op_i == dscs_pkg::DSCS_OP_SET |=> nv_opt_o;
  endproperty
  a_nv_set: assert property (p_nv_set)
    else $error("option set not stored");

  property p_sel_ignored;
    @(posedge core_clk_i) disable iff (srst_i)
      !dsm_act_reg |-> &per_slow;
  endproperty
  a_sel_ignored: assert property (p_sel_ignored)
    else $error("select bit active in standard mode");

  property p_serial_mode;
    @(posedge core_clk_i) disable iff (srst_i)
      serial_mode_i == 2'h1 |-> per_slow[`DSCS_BIT_SP-1];
  endproperty
  a_serial_mode: assert property (p_serial_mode)
    else $error("serial select acted in mode 1");

  property p_sel_fast;
    @(posedge core_clk_i) disable iff (srst_i)
      dsm_act_reg && !css_reg[`DSCS_BIT_T0] |-> !per_slow[0];
  endproperty
  a_sel_fast: assert property (p_sel_fast)
    else $error("timer zero not fast");

  c_enter_ds: cover property (@(posedge core_clk_i) $rose(dsm_act_reg));
  c_leave_ds: cover property (@(posedge core_clk_i) $fell(dsm_act_reg));
  c_mc: cover property (@(posedge core_clk_i) mach_cycle_o && dsm_act_reg);
  c_nv_start: cover property (@(posedge core_clk_i) init_reg && nv_opt_o);
  c_sp_fast: cover property (@(posedge core_clk_i)
    dsm_act_reg && !per_slow[`DSCS_BIT_SP-1]);

  property p_rd_data;
    @(posedge core_clk_i) disable iff (srst_i)
      !srst_i && css_hit && !sfr_req_i.wr
        |=> sfr_rdata_o == $past(css_reg);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read data differs from register");
endmodule

//--- logic/dscs_defines.svh
// Purpose: constants for the double speed clock select block
// Assumes: sfr bus with 8-bit data and 8-bit direct address
// Notes: bit positions follow the clock speed select register layout
`ifndef DSCS_DEFINES_SVH
`define DSCS_DEFINES_SVH
`define DSCS_CSS_ADDR 8'h8F
`define DSCS_CSS_RESET 8'h00
`define DSCS_BIT_DSM 0
`define DSCS_BIT_T0 1
`define DSCS_BIT_T1 2
`define DSCS_BIT_T2 3
`define DSCS_BIT_SP 4
`define DSCS_BIT_CA 5
`define DSCS_BIT_WD 6
`define DSCS_BIT_CAN 7
`define DSCS_PER_FAST 3'h5
`define DSCS_PER_SLOW 4'hB
`define DSCS_NUM_PER 7
`endif

//--- logic/dscs_pkg.sv
// Purpose: types for the double speed clock select block
// Assumes: included constants header
// Notes: none
package dscs_pkg;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dscs_sfr_req_t;
  typedef enum logic [1:0] {DSCS_OP_READ, DSCS_OP_SET, DSCS_OP_CLEAR,
    DSCS_OP_NONE} dscs_nv_op_t;
endpackage

//--- logic/dscs_per_div.sv
// Purpose: peripheral tick generator from the crystal tick stream
// Assumes: tick_i is one pulse per crystal period seen by the block
// Notes: period is 6 or 12 ticks chosen by slow_i
`timescale 1ns/1ps
`include "dscs_defines.svh"
module dscs_per_div (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic slow_i,
  output logic pulse_o
);
  logic [3:0] cnt_reg;
  logic [3:0] top;
  assign top = slow_i ? `DSCS_PER_SLOW : {1'b0, `DSCS_PER_FAST};
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_reg <= 4'h0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= 1'b0;
      if (tick_i) begin
        // a shortened top mid-count wraps rather than overrunning
        if (cnt_reg >= top) begin
          cnt_reg <= 4'h0;
          pulse_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule

//--- test/dscs_xtal_model.sv
// Purpose: crystal source feeding the clock block
// Assumes: free running oscillator, phase unrelated to core clock
// Notes: even duty keeps well inside the double speed window
`timescale 1ns/1ps
module dscs_xtal_model #(
  parameter int HALF_NS = 16
) (
  output logic crystal_o
);
  initial begin
    crystal_o = 1'b0;
    #3;
    forever #(HALF_NS) crystal_o = ~crystal_o;
  end
endmodule

//--- test/tb_top.sv
// Purpose: self checking bench for the clock select block
// Assumes: one crystal period is eight core clock periods
// Notes: tick spacing is measured in core cycles
`timescale 1ns/1ps
`include "dscs_defines.svh"
module tb_top;
  logic clk, srst, xtal, nv_valid, nv_opt, dsm, ph, mc;
  logic [1:0] smode;
  logic [7:0] rdata;
  logic [6:0] pt;
  dscs_pkg::dscs_sfr_req_t req;
  dscs_pkg::dscs_nv_op_t nv_op;
  int err_count, total_checks;
  dscs_xtal_model dscs_xtal_model_inst (.crystal_o(xtal));
  dscs_top dscs_top_inst (.core_clk_i(clk), .srst_i(srst),
    .crystal_input_i(xtal), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .nv_op_i(nv_op), .nv_op_valid_i(nv_valid), .nv_opt_o(nv_opt),
    .serial_mode_i(smode), .double_speed_mode_o(dsm),
    .phase_tick_o(ph), .mach_cycle_o(mc), .per_tick_o(pt));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string nm, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) #1 req = '{1'b1, 1'b1, a, d};
    @(posedge clk) #1 req.sel = 1'b0;
  endtask
  task automatic rd(input logic [7:0] e);
    @(posedge clk) #1 req = '{1'b1, 1'b0, `DSCS_CSS_ADDR, 8'h00};
    @(posedge clk) #1 req.sel = 1'b0;
    check("rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  function automatic logic pick(input int k);
    return k == 7 ? mc : k == 8 ? ph : pt[k];
  endfunction
  // first pulse only aligns; the second closes the measured gap
  task automatic gap(input int k, input logic [15:0] e);
    int n;
    n = 0;
    while (pick(k) !== 1'b1 && n < 400) begin
      @(posedge clk) #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk) #1;
      n++;
    end while (pick(k) !== 1'b1 && n < 400);
    check($sformatf("gap%0d", k), n[15:0], e);
  endtask
  task automatic allgap(input logic [6:0] slow);
    for (int k = 0; k < 7; k++) gap(k, slow[k] ? 16'd96 : 16'd48);
  endtask
  task automatic waitdsm(input logic v);
    int n;
    n = 0;
    while (dsm !== v && n < 100) begin
      @(posedge clk) #1;
      n++;
    end
    check("mode", {15'h0, dsm}, {15'h0, v});
  endtask
  task automatic nv(input dscs_pkg::dscs_nv_op_t op);
    @(posedge clk) #1 nv_op = op;
    nv_valid = 1'b1;
    @(posedge clk) #1 nv_valid = 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic rst();
    srst = 1'b1;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
  initial begin
    req = '0;
    nv_op = dscs_pkg::DSCS_OP_NONE;
    nv_valid = 1'b0;
    smode = 2'd0;
    err_count = 0;
    total_checks = 0;
    rst();
    rd(`DSCS_CSS_RESET);
    check("mode", {15'h0, dsm}, 16'h0);
    gap(7, 16'd96);
    gap(8, 16'd16);
    allgap(7'h7F);
    $display("standard test done");
    wr(`DSCS_CSS_ADDR, 8'h01);
    waitdsm(1'b1);
    rd(8'h01);
    gap(7, 16'd48);
    gap(8, 16'd8);
    allgap(7'h00);
    wr(`DSCS_CSS_ADDR, 8'hAB);
    allgap(7'h55);
    wr(`DSCS_CSS_ADDR, 8'h01);
    smode = 2'd1;
    gap(3, 16'd96);
    smode = 2'd2;
    gap(3, 16'd48);
    wr(8'h8E, 8'h00);
    rd(8'h01);
    wr(`DSCS_CSS_ADDR, 8'h00);
    waitdsm(1'b0);
    gap(7, 16'd96);
    $display("double speed test done");
    nv(dscs_pkg::DSCS_OP_SET);
    check("nvopt", {15'h0, nv_opt}, 16'h1);
    rst();
    check("mode", {15'h0, dsm}, 16'h1);
    rd(8'h01);
    gap(7, 16'd48);
    nv(dscs_pkg::DSCS_OP_READ);
    check("nvopt", {15'h0, nv_opt}, 16'h1);
    nv(dscs_pkg::DSCS_OP_CLEAR);
    check("nvopt", {15'h0, nv_opt}, 16'h0);
    $display("start option test done");
    finish_test();
  end
endmodule
